// ### src/obc_option_byte_config_decode.sv
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module obc_option_byte_config_decode
  import obc_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [3:0] WB_ADR_IN,
  input wire logic [31:0] WB_DAT_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic WB_WE_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  output logic WB_ERR_OUT,
  output logic [1:0] CLOCK_SOURCE_OUT,
  output logic INTERNAL_RC_ON_OUT,
  output logic [2:0] SECTOR_ZERO_KB2_OUT,
  output logic READOUT_PROTECT_OUT,
  output logic WRITE_PROTECT_OUT,
  output logic [3:0] PLL_FACTOR_OUT,
  output logic PLL_ENABLE_OUT,
  output logic LVD_ENABLE_OUT,
  output logic [1:0] LVD_LEVEL_OUT,
  output logic WATCHDOG_HW_ENABLE_OUT,
  output logic WATCHDOG_HALT_RESET_OUT,
  output logic WAKEUP_CLOCK_SELECT_OUT,
  output logic [2:0] OSCILLATOR_RANGE_OUT,
  output logic EEPROM_READOUT_PROTECT_OUT
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic prog_q;
  logic rom_q;
  logic [7:0] opt0_q;
  logic [7:0] opt1_q;
  logic mem_erased_q;
  logic refused_q;
  logic ack_q;
  logic err_q;
  logic [31:0] rdat_q;
  logic req;
  logic hit_ctrl, hit_opt0, hit_opt1, hit_stat, hit_any;
  logic wr_opt, wr_ctrl, erase_req, wp_lock;

  assign req = WB_CYC_IN & WB_STB_IN & ~ack_q & ~err_q;
  assign hit_ctrl = WB_ADR_IN == OBC_ADR_CTRL;
  assign hit_opt0 = WB_ADR_IN == OBC_ADR_OPT0;
  assign hit_opt1 = WB_ADR_IN == OBC_ADR_OPT1;
  assign hit_stat = WB_ADR_IN == OBC_ADR_STAT;
  assign hit_any = hit_ctrl | hit_opt0 | hit_opt1 | hit_stat;
  assign wp_lock = ~rom_q & opt0_q[OBC_B0_WRP];
  assign wr_opt = req & WB_WE_IN & WB_SEL_IN[0] & prog_q & (hit_opt0 | hit_opt1) & ~wp_lock;
  assign wr_ctrl = req & WB_WE_IN & WB_SEL_IN[0] & hit_ctrl;
  assign erase_req = wr_ctrl & prog_q & WB_DAT_IN[OBC_CTL_ERASE] & ~wp_lock;

  // ---------------------------------------------------------------
  // bus answer: registered ack one cycle after the request, err on unmapped address
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ack_q <= req & hit_any;
      err_q <= req & ~hit_any;
    end
  end

  // ---------------------------------------------------------------
  // mode control
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      prog_q <= 1'b0;
      rom_q <= 1'b0;
    end else if (wr_ctrl) begin
      prog_q <= WB_DAT_IN[OBC_CTL_PROG];
      // variant may only change in programming mode, and never once locked:
      // switching to rom would otherwise drop the flash write lock
      if (prog_q && !wp_lock) begin
        rom_q <= WB_DAT_IN[OBC_CTL_ROMV];
      end
    end
  end

  // ---------------------------------------------------------------
  // option byte store
  // ---------------------------------------------------------------
  // kept in flops for this model; a real part would back it with nvm
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      opt0_q <= OBC_FL_DEF0;
      opt1_q <= OBC_FL_DEF1;
    end else if (erase_req) begin
      opt0_q <= rom_q ? OBC_ROM_DEF0 : OBC_FL_DEF0;
      opt1_q <= rom_q ? OBC_ROM_DEF1 : OBC_FL_DEF1;
    end else if (wr_opt && hit_opt0) begin
      opt0_q <= WB_DAT_IN[7:0];
    end else if (wr_opt && hit_opt1) begin
      opt1_q <= WB_DAT_IN[7:0];
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mem_erased_q <= 1'b0;
    end else if (erase_req && opt0_q[OBC_B0_RDP]) begin
      mem_erased_q <= 1'b1;
    end else if (wr_ctrl && !WB_DAT_IN[OBC_CTL_PROG]) begin
      mem_erased_q <= 1'b0;
    end
  end

  // sticky: an option write refused by lock, mode or byte lane 0 not selected
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      refused_q <= 1'b0;
    end else if (req && WB_WE_IN && (hit_opt0 || hit_opt1) && !wr_opt) begin
      refused_q <= 1'b1;
    end else if (wr_ctrl && prog_q && !WB_DAT_IN[OBC_CTL_PROG]) begin
      refused_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rdat_q <= OBC_ZERO32;
    end else if (req && !WB_WE_IN) begin
      rdat_q <= OBC_ZERO32;
      if (hit_ctrl) begin
        rdat_q[OBC_CTL_PROG] <= prog_q;
        rdat_q[OBC_CTL_ROMV] <= rom_q;
      end
      if (hit_opt0 && prog_q) begin
        rdat_q[7:0] <= opt0_q;
      end
      if (hit_opt1 && prog_q) begin
        rdat_q[7:0] <= opt1_q;
      end
      if (hit_stat) begin
        rdat_q[OBC_ST_PROG] <= prog_q;
        rdat_q[OBC_ST_MEMERASED] <= mem_erased_q;
        rdat_q[OBC_ST_WPLOCK] <= wp_lock;
        rdat_q[OBC_ST_REFUSED] <= refused_q;
      end
    end
  end

  assign WB_ACK_OUT = ack_q;
  assign WB_ERR_OUT = err_q;
  assign WB_DAT_OUT = rdat_q;

  // ---------------------------------------------------------------
  // decoded configuration
  // ---------------------------------------------------------------
  logic [1:0] clk_d;
  logic [2:0] size_d;
  always_comb begin
    case (opt0_q[OBC_B0_CLK_HI:OBC_B0_CLK_LO])
      OBC_CLK_RES: clk_d = OBC_CLK_RES;
      OBC_CLK_PB: clk_d = OBC_CLK_PB;
      OBC_CLK_PC: clk_d = OBC_CLK_PC;
      default: clk_d = OBC_CLK_RSV;
    endcase
    case (opt0_q[OBC_B0_SZ_HI:OBC_B0_SZ_LO])
      2'h0: size_d = OBC_SZ_HALF;
      2'h1: size_d = OBC_SZ_1K;
      2'h2: size_d = OBC_SZ_2K;
      default: size_d = OBC_SZ_4K;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      CLOCK_SOURCE_OUT <= OBC_CLK_PC;
      INTERNAL_RC_ON_OUT <= 1'b1;
      SECTOR_ZERO_KB2_OUT <= OBC_SZ_1K;
      READOUT_PROTECT_OUT <= 1'b0;
      WRITE_PROTECT_OUT <= 1'b0;
      PLL_FACTOR_OUT <= OBC_PLL_X8;
      PLL_ENABLE_OUT <= 1'b0;
      LVD_ENABLE_OUT <= 1'b0;
      LVD_LEVEL_OUT <= OBC_LVD_OFF;
      WATCHDOG_HW_ENABLE_OUT <= 1'b0;
      WATCHDOG_HALT_RESET_OUT <= 1'b1;
      WAKEUP_CLOCK_SELECT_OUT <= 1'b0;
      OSCILLATOR_RANGE_OUT <= 3'h0;
      EEPROM_READOUT_PROTECT_OUT <= 1'b0;
    end else if (!prog_q) begin
      CLOCK_SOURCE_OUT <= (rom_q | ~opt1_q[OBC_B1_RC]) ? OBC_CLK_PC : clk_d;
      INTERNAL_RC_ON_OUT <= ~opt1_q[OBC_B1_RC];
      SECTOR_ZERO_KB2_OUT <= rom_q ? OBC_SZ_4K : size_d;
      READOUT_PROTECT_OUT <= opt0_q[OBC_B0_RDP];
      WRITE_PROTECT_OUT <= wp_lock;
      PLL_FACTOR_OUT <= (rom_q | opt1_q[OBC_B1_PLLF]) ? OBC_PLL_X8 : OBC_PLL_X4;
      PLL_ENABLE_OUT <= ~opt1_q[OBC_B1_PLL_BYP];
      LVD_ENABLE_OUT <= opt1_q[OBC_B1_LVD_HI:OBC_B1_LVD_LO] != OBC_LVD_OFF;
      LVD_LEVEL_OUT <= opt1_q[OBC_B1_LVD_HI:OBC_B1_LVD_LO];
      WATCHDOG_HW_ENABLE_OUT <= ~opt1_q[OBC_B1_WDSW];
      WATCHDOG_HALT_RESET_OUT <= opt1_q[OBC_B1_WDHALT];
      WAKEUP_CLOCK_SELECT_OUT <= rom_q & opt0_q[OBC_B0_AWU];
      OSCILLATOR_RANGE_OUT <= rom_q ? opt0_q[OBC_B0_OSR_HI:OBC_B0_OSR_LO] : 3'h0;
      EEPROM_READOUT_PROTECT_OUT <= rom_q & opt0_q[OBC_B0_EERDP];
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  a_cfg_held_prog: assert property ($past(prog_q) |-> $stable(PLL_ENABLE_OUT))
    else $error("config changed during programming");
  a_hidden_read: assert property (req && !WB_WE_IN && hit_opt0 && !prog_q
      |=> WB_ACK_OUT && WB_DAT_OUT == OBC_ZERO32)
    else $error("option byte visible outside programming");
  a_wp_locks: assert property (wp_lock |=> wp_lock)
    else $error("write protect cleared");
  a_pll_bypass: assert property (!prog_q && !rom_q
      |=> PLL_ENABLE_OUT == !$past(opt1_q[OBC_B1_PLL_BYP]))
    else $error("pll enable mismatch");
  a_pll_factor: assert property (!prog_q && !rom_q && !opt1_q[OBC_B1_PLLF]
      |=> PLL_FACTOR_OUT == OBC_PLL_X4)
    else $error("pll factor mismatch");
  a_lvd_off: assert property (!prog_q && opt1_q[OBC_B1_LVD_HI:OBC_B1_LVD_LO] == OBC_LVD_OFF
      |=> !LVD_ENABLE_OUT)
    else $error("lvd not off");
  a_erase_wipe: assert property (erase_req && opt0_q[OBC_B0_RDP] |=> mem_erased_q && !opt0_q[OBC_B0_RDP])
    else $error("erase did not wipe memory");
  a_rdp_out: assert property (!prog_q |=> READOUT_PROTECT_OUT == $past(opt0_q[OBC_B0_RDP]))
    else $error("readout protect mismatch");
  a_wdg_hw: assert property (!prog_q |=> WATCHDOG_HW_ENABLE_OUT == !$past(opt1_q[OBC_B1_WDSW]))
    else $error("watchdog mode mismatch");
  a_wdg_halt: assert property (!prog_q |=> WATCHDOG_HALT_RESET_OUT == $past(opt1_q[OBC_B1_WDHALT]))
    else $error("halt reset mismatch");
  a_rc_clock: assert property (!prog_q && !opt1_q[OBC_B1_RC] |=> INTERNAL_RC_ON_OUT
      && CLOCK_SOURCE_OUT == OBC_CLK_PC)
    else $error("rc select mismatch");

  a_clk_select: assert property (!prog_q && !rom_q && opt1_q[OBC_B1_RC]
      |=> CLOCK_SOURCE_OUT == $past(opt0_q[OBC_B0_CLK_HI:OBC_B0_CLK_LO]))
    else $error("clock source mismatch");
  a_sector_2k: assert property (!prog_q && !rom_q
      && opt0_q[OBC_B0_SZ_HI:OBC_B0_SZ_LO] == 2'h2 |=> SECTOR_ZERO_KB2_OUT == OBC_SZ_2K)
    else $error("sector size mismatch");
  a_rom_layout: assert property (!prog_q && rom_q
      |=> PLL_FACTOR_OUT == OBC_PLL_X8 && !WRITE_PROTECT_OUT)
    else $error("rom variant decode mismatch");
  a_opt_gated: assert property (req && WB_WE_IN && (hit_opt0 || hit_opt1) && !prog_q
      |=> $stable(opt0_q) && $stable(opt1_q))
    else $error("option byte written outside programming");

  c_write_opt: cover property (wr_opt ##1 WB_ACK_OUT);
  c_erase_rdp: cover property (erase_req && opt0_q[OBC_B0_RDP]);
  c_refused: cover property (req && WB_WE_IN && hit_opt0 && !prog_q);
  c_unmapped: cover property (WB_ERR_OUT);
  c_rom_mode: cover property (!prog_q && rom_q);

endmodule // obc_option_byte_config_decode

// ### src/obc_pkg.sv
package obc_pkg;
  // ---------------------------------------------------------------
  // register map (word offsets as byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] OBC_ADR_CTRL = 4'h0;
  localparam logic [3:0] OBC_ADR_OPT0 = 4'h4;
  localparam logic [3:0] OBC_ADR_OPT1 = 4'h8;
  localparam logic [3:0] OBC_ADR_STAT = 4'hC;
  // ctrl bits
  localparam int OBC_CTL_PROG = 0;
  localparam int OBC_CTL_ERASE = 1;
  localparam int OBC_CTL_ROMV = 2;
  // status bits
  localparam int OBC_ST_PROG = 0;
  localparam int OBC_ST_MEMERASED = 1;
  localparam int OBC_ST_WPLOCK = 2;
  localparam int OBC_ST_REFUSED = 3;
  // ---------------------------------------------------------------
  // option byte fields and defaults
  // ---------------------------------------------------------------
  localparam int OBC_B0_CLK_HI = 5;
  localparam int OBC_B0_CLK_LO = 4;
  localparam int OBC_B0_SZ_HI = 3;
  localparam int OBC_B0_SZ_LO = 2;
  localparam int OBC_B0_RDP = 1;
  localparam int OBC_B0_WRP = 0;
  localparam int OBC_B0_AWU = 7;
  localparam int OBC_B0_OSR_HI = 6;
  localparam int OBC_B0_OSR_LO = 4;
  localparam int OBC_B0_ROMRDP = 1;
  localparam int OBC_B0_EERDP = 0;
  localparam int OBC_B1_PLLF = 7;
  localparam int OBC_B1_PLL_BYP = 6;
  localparam int OBC_B1_RC = 4;
  localparam int OBC_B1_LVD_HI = 3;
  localparam int OBC_B1_LVD_LO = 2;
  localparam int OBC_B1_WDSW = 1;
  localparam int OBC_B1_WDHALT = 0;
  localparam logic [7:0] OBC_FL_DEF0 = 8'h74;
  localparam logic [7:0] OBC_FL_DEF1 = 8'hEF;
  localparam logic [7:0] OBC_ROM_DEF0 = 8'hFC;
  localparam logic [7:0] OBC_ROM_DEF1 = 8'hCF;
  // ---------------------------------------------------------------
  // decoded values
  // ---------------------------------------------------------------
  localparam logic [1:0] OBC_CLK_RES = 2'h0;
  localparam logic [1:0] OBC_CLK_PB = 2'h1;
  localparam logic [1:0] OBC_CLK_RSV = 2'h2;
  localparam logic [1:0] OBC_CLK_PC = 2'h3;
  localparam logic [1:0] OBC_LVD_OFF = 2'h3;
  localparam logic [3:0] OBC_PLL_X4 = 4'h4;
  localparam logic [3:0] OBC_PLL_X8 = 4'h8;
  localparam logic [2:0] OBC_SZ_HALF = 3'h0;
  localparam logic [2:0] OBC_SZ_1K = 3'h1;
  localparam logic [2:0] OBC_SZ_2K = 3'h2;
  localparam logic [2:0] OBC_SZ_4K = 3'h4;
  localparam logic [31:0] OBC_ZERO32 = 32'h0000_0000;
endpackage

// ### verification/obc_prog_tool.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// programming tool: classic wishbone master
// ---------------------------------------------------------------
module obc_prog_tool (
  input wire logic clk_in,
  input wire logic [31:0] dat_in,
  input wire logic ack_in,
  input wire logic err_in,
  output logic [3:0] adr_out,
  output logic [31:0] dat_out,
  output logic [3:0] sel_out,
  output logic we_out,
  output logic cyc_out,
  output logic stb_out
);
  initial begin
    adr_out = 4'h0;
    dat_out = 32'h0000_0000;
    sel_out = 4'h0;
    we_out = 1'b0;
    cyc_out = 1'b0;
    stb_out = 1'b0;
  end
  // bytes reached only over this bus
  task automatic xfer(input logic we, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk_in);
    cyc_out <= 1'b1;
    stb_out <= 1'b1;
    we_out <= we;
    adr_out <= a;
    dat_out <= d;
    sel_out <= 4'h1;
    do @(posedge clk_in); while (ack_in !== 1'b1 && err_in !== 1'b1);
    q = dat_in;
    e = err_in;
    cyc_out <= 1'b0;
    stb_out <= 1'b0;
    // released bus shows no stale data
    dat_out <= ~d;
    adr_out <= ~a;
  endtask
endmodule // obc_prog_tool

// ### verification/option_byte_config_decode_tb.sv
`timescale 1ns/1ps
module option_byte_config_decode_tb;
  import obc_pkg::*;
  logic CLK_IN, RST_N_IN, wb_we, wb_cyc, wb_stb, ack_o, err_o, er, rc_on, rdp, wrp;
  logic pll_en, lvd_en, wd_hw, wd_halt, awu, ee_rdp, rcoff, rom;
  logic [3:0] wb_adr, wb_sel, pll_f;
  logic [31:0] wb_wdat, dat_o, rd, lfsr_q;
  logic [1:0] clk_src, lvd_lvl, cs;
  logic [2:0] s0_size, osr;
  logic [7:0] b0, b1;
  logic [31:0] exp_q[$];
  int error_cnt, checked;
  obc_option_byte_config_decode uut (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
    .WB_ADR_IN(wb_adr), .WB_DAT_IN(wb_wdat), .WB_SEL_IN(wb_sel), .WB_WE_IN(wb_we),
    .WB_CYC_IN(wb_cyc), .WB_STB_IN(wb_stb), .WB_DAT_OUT(dat_o), .WB_ACK_OUT(ack_o),
    .WB_ERR_OUT(err_o), .CLOCK_SOURCE_OUT(clk_src), .INTERNAL_RC_ON_OUT(rc_on),
    .SECTOR_ZERO_KB2_OUT(s0_size), .READOUT_PROTECT_OUT(rdp), .WRITE_PROTECT_OUT(wrp),
    .PLL_FACTOR_OUT(pll_f), .PLL_ENABLE_OUT(pll_en), .LVD_ENABLE_OUT(lvd_en),
    .LVD_LEVEL_OUT(lvd_lvl), .WATCHDOG_HW_ENABLE_OUT(wd_hw),
    .WATCHDOG_HALT_RESET_OUT(wd_halt), .WAKEUP_CLOCK_SELECT_OUT(awu),
    .OSCILLATOR_RANGE_OUT(osr), .EEPROM_READOUT_PROTECT_OUT(ee_rdp));
  obc_prog_tool tool (.clk_in(CLK_IN), .dat_in(dat_o), .ack_in(ack_o), .err_in(err_o),
    .adr_out(wb_adr), .dat_out(wb_wdat), .sel_out(wb_sel), .we_out(wb_we),
    .cyc_out(wb_cyc), .stb_out(wb_stb));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
  endfunction
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    tool.xfer(1'b1, a, {24'h00_0000, d}, rd, er);
  endtask
  task automatic rdx(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    tool.xfer(1'b0, a, 32'h0000_0000, rd, er);
  endtask
  task automatic check_cfg();
    cmp("clk_src", (b1[4] && !rom) ? b0[5:4] : 2'h3, clk_src);
    cmp("rc_on", !b1[4], rc_on);
    cmp("sector", (rom || b0[3:2] == 2'h3) ? OBC_SZ_4K : b0[3:2], s0_size);
    cmp("rdp", b0[1], rdp);
    cmp("wrp", b0[0] && !rom, wrp);
    cmp("pll_f", (b1[7] || rom) ? OBC_PLL_X8 : OBC_PLL_X4, pll_f);
    cmp("pll_en", !b1[6], pll_en);
    cmp("lvd_en", b1[3:2] != 2'h3, lvd_en);
    cmp("lvd_lvl", b1[3:2], lvd_lvl);
    cmp("wd_hw", !b1[1], wd_hw);
    cmp("wd_halt", b1[0], wd_halt);
    cmp("rom_fields", rom ? {b0[7:4], b0[0]} : 5'h00, {awu, osr, ee_rdp});
  endtask
  task automatic load(input logic [7:0] x0, input logic [7:0] x1);
    wr(OBC_ADR_CTRL, 8'h01);
    wr(OBC_ADR_OPT0, x0);
    wr(OBC_ADR_OPT1, x1);
    rdx(OBC_ADR_OPT0, {24'h00_0000, x0});
    rdx(OBC_ADR_OPT1, {24'h00_0000, x1});
    repeat (2) @(posedge CLK_IN);
    check_cfg();
    b0 = x0;
    b1 = x1;
    wr(OBC_ADR_CTRL, 8'h00);
    repeat (2) @(posedge CLK_IN);
    check_cfg();
  endtask
  // ---------------------------------------------------------------
  // read data scoreboard
  // ---------------------------------------------------------------
  always @(posedge CLK_IN) begin
    if (ack_o === 1'b1 && wb_we === 1'b0) begin
      cmp("rdata", exp_q.pop_front(), dat_o);
    end
  end
  initial begin
    CLK_IN = 1'b0;
    forever #2.5 CLK_IN = ~CLK_IN;
  end
  initial begin
    repeat (20000) @(posedge CLK_IN);
    error_cnt++;
    close_out();
  end
  initial begin
    RST_N_IN = 1'b0;
    lfsr_q = 32'h98fd_3ef7;
    rom = 1'b0;
    b0 = OBC_FL_DEF0;
    b1 = OBC_FL_DEF1;
    repeat (5) @(posedge CLK_IN);
    RST_N_IN <= 1'b1;
    repeat (2) @(posedge CLK_IN);
    check_cfg();
    // a write outside programming mode is flagged and leaves the byte alone
    wr(OBC_ADR_OPT0, 8'h00);
    rdx(OBC_ADR_STAT, 32'h0000_0008);
    rdx(OBC_ADR_OPT0, 32'h0000_0000);
    tool.xfer(1'b0, 4'h2, 32'h0000_0000, rd, er);
    cmp("unmapped_err", 1'b1, er);
    for (int i = 0; i < 8; i++) begin
      lfsr_q = lfsr(lfsr_q);
      rcoff = !i[2];
      // rc mode keeps default select, reserved bits as required
      cs = rcoff ? i[1:0] : 2'h3;
      load({2'b01, cs, lfsr_q[3:2], 2'b00},
           {lfsr_q[7:6], 1'b1, rcoff, 1'b1, lfsr_q[2:0]});
    end
    // readout protected erase wipes memory and restores defaults
    load(8'h76, b1);
    wr(OBC_ADR_CTRL, 8'h01);
    wr(OBC_ADR_CTRL, 8'h03);
    rdx(OBC_ADR_STAT, 32'h0000_0003);
    rdx(OBC_ADR_OPT0, {24'h00_0000, OBC_FL_DEF0});
    wr(OBC_ADR_CTRL, 8'h00);
    b0 = OBC_FL_DEF0;
    b1 = OBC_FL_DEF1;
    repeat (2) @(posedge CLK_IN);
    check_cfg();
    // rom variant: own layout of byte 0, x8 only; erase, clear the variant bit to leave it, erase again
    wr(OBC_ADR_CTRL, 8'h01);
    wr(OBC_ADR_CTRL, 8'h05);
    wr(OBC_ADR_OPT0, 8'hDF);
    wr(OBC_ADR_OPT1, 8'h9A);
    rdx(OBC_ADR_OPT1, 32'h0000_009A);
    wr(OBC_ADR_CTRL, 8'h04);
    rom = 1'b1;
    b0 = 8'hDF;
    b1 = 8'h9A;
    repeat (2) @(posedge CLK_IN);
    check_cfg();
    wr(OBC_ADR_CTRL, 8'h05);
    wr(OBC_ADR_CTRL, 8'h07);
    rdx(OBC_ADR_OPT0, {24'h00_0000, OBC_ROM_DEF0});
    wr(OBC_ADR_CTRL, 8'h01);
    wr(OBC_ADR_CTRL, 8'h03);
    wr(OBC_ADR_CTRL, 8'h00);
    rom = 1'b0;
    b0 = OBC_FL_DEF0;
    b1 = OBC_FL_DEF1;
    // write lock is permanent: writes and erase both ignored
    load(8'h75, b1);
    wr(OBC_ADR_CTRL, 8'h01);
    wr(OBC_ADR_OPT0, 8'h74);
    rdx(OBC_ADR_STAT, 32'h0000_000D);
    rdx(OBC_ADR_OPT0, 32'h0000_0075);
    wr(OBC_ADR_CTRL, 8'h03);
    rdx(OBC_ADR_OPT0, 32'h0000_0075);
    repeat (3) @(posedge CLK_IN);
    close_out();
  end
endmodule // option_byte_config_decode_tb
